// [spc_pkg.sv]
// constants, field layouts and carrier types for the serial port
// control and status block; assumes a 32-bit avalon-mm register bus
package spc_pkg;

  // -----------------------------------------------------------------
  // register map (byte addresses)
  // -----------------------------------------------------------------
  localparam int unsigned SPC_ADDR_W = 5;
  localparam int unsigned SPC_DATA_W = 32;
  localparam logic [4:0]  SPC_OFS_ENABLE  = 5'h00;
  localparam logic [4:0]  SPC_OFS_CONTROL = 5'h04;
  localparam logic [4:0]  SPC_OFS_STATUS  = 5'h08;
  localparam logic [4:0]  SPC_OFS_TXDATA  = 5'h0C;
  localparam logic [4:0]  SPC_OFS_RXDATA  = 5'h10;

  // -----------------------------------------------------------------
  // field positions and reset values
  // -----------------------------------------------------------------
  localparam int unsigned SPC_EN_BIT      = 0;
  localparam int unsigned SPC_SOFT_RST_BIT = 4;
  localparam int unsigned SPC_STS_TXE_BIT = 0;
  localparam int unsigned SPC_STS_RXF_BIT = 1;
  localparam int unsigned SPC_STS_ACT_BIT = 2;
  localparam logic [6:0]  SPC_CTRL_RESET  = 7'h02;
  localparam logic [7:0]  SPC_BYTE_RESET  = 8'h00;
  localparam logic [1:0]  SPC_SEL_FULL    = 2'h0;
  localparam logic [1:0]  SPC_SEL_HALF    = 2'h1;
  localparam int unsigned SPC_DUAL_BIT    = 1;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned SPC_CLK_PERIOD_NS  = 50;
  localparam int unsigned SPC_SCLK_PERIOD_NS = 400;
  localparam int unsigned SPC_BYTE_BITS      = 8;
  // half serial clock period in system clocks, rounded up
  localparam int unsigned SPC_SCLK_HALF_CYC  =
    (SPC_SCLK_PERIOD_NS + 2 * SPC_CLK_PERIOD_NS - 1) /
    (2 * SPC_CLK_PERIOD_NS);

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic {SPC_SH_IDLE, SPC_SH_RUN} spc_shift_e;

  typedef struct packed {
    logic       cs_on;
    logic       auto_read;
    logic       soft_rst;
    logic [1:0] input_pin_choice;
    logic       out_pin_drive_dir;
    logic       low_bit_first;
  } spc_ctrl_s;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic serial_out_pin;
    logic out_pin_dir_signal;
  } spc_link_s;

endpackage

// [spc_serial_ctrl.sv]
// serial port master: control and status registers, shifter, pins
// assumes an avalon-mm master on clock_i and a slave on the link pins
//
// Overview of operation
// - control bit 6 set drives select low
// - auto-read: rx read clears both flags
// - no auto-read: rx read clears rx-full only
// - soft reset self-clears; writing zero does nothing
// - soft reset returns whole interface to reset
// - input select chooses sampled input pins when the direction bit is zero
// - half/dual: direction bit sets pin direction
// - direction change applied only between bytes
// - control bit 0 selects lsb-first order
// - rx-full set on full byte, read clears
// - rx-full drives receive interrupt request
// - tx-empty resets one, tx write clears
// - tx-empty drives transmit interrupt request
// - direction bit resets to one (output)
// - disabled: clocks stop, clock and data-out held low
// - tx write starts transfer; pending byte follows
// - eight clock pulses complete byte, rx-full sets
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
module spc_serial_ctrl #(
  parameter int unsigned SCLK_HALF = spc_pkg::SPC_SCLK_HALF_CYC
) (
  input  wire logic                          clock_i,
  input  wire logic                          sys_rst_i,
  input  wire logic [spc_pkg::SPC_ADDR_W-1:0] avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [spc_pkg::SPC_DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [spc_pkg::SPC_DATA_W-1:0] avs_readdata_o,
  output logic                               avs_waitrequest_o,
  input  wire logic                          serial_in_first_i,
  input  wire logic                          serial_in_second_i,
  output spc_pkg::spc_link_s                 link_o,
  output logic                               rx_irq_o,
  output logic                               tx_irq_o
);
  import spc_pkg::*;

  localparam int unsigned HCW = $clog2(SCLK_HALF + 1) + 1;
  localparam int unsigned BCW = $clog2(SPC_BYTE_BITS) + 1;

  // -----------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------
  generate
    if (SCLK_HALF < 1) begin : g_bad_half
      $error("SCLK_HALF must be at least one cycle");
    end
  endgenerate

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  // word hit: low address bits must be zero for an aligned access
  function automatic logic reg_hit(input logic [SPC_ADDR_W-1:0] addr,
                                   input logic [SPC_ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // choose the receive bit from the synchronised inputs
  function automatic logic pick_bit(input logic [1:0] sel,
                                    input logic       dir_out,
                                    input logic       odd_bit,
                                    input logic [1:0] pins);
    logic b;
    b = pins[0];
    if (!dir_out) begin
      if (sel[SPC_DUAL_BIT]) begin
        b = odd_bit ? pins[1] : pins[0];
      end else if (sel == SPC_SEL_HALF) begin
        b = pins[1];
      end else begin
        b = pins[0];
      end
    end
    pick_bit = b;
  endfunction

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic                  wreq_ff;
  logic [SPC_DATA_W-1:0] rdata_ff;
  logic                  enable_ff;
  spc_ctrl_s             ctrl_ff;
  logic [7:0]            tx_hold_ff;
  logic                  pending_ff;
  logic                  tx_empty_ff;
  logic [7:0]            rx_data_ff;
  logic                  rx_full_ff;
  spc_shift_e            state_ff;
  logic [HCW-1:0]        half_cnt_ff;
  logic [BCW-1:0]        bit_cnt_ff;
  logic [7:0]            tx_sh_ff;
  logic [7:0]            rx_sh_ff;
  logic                  order_ff;
  logic [1:0]            sel_ff;
  logic                  dir_ff;
  logic                  sclk_ff;
  logic                  sdout_ff;
  logic                  cs_n_ff;
  logic [1:0]            sync1_ff;
  logic [1:0]            sync2_ff;
  logic                  acc_wr;
  logic                  acc_rd;
  logic                  blk_rst;
  logic                  load;
  logic                  half_tick;
  logic                  byte_done;
  logic                  in_bit;
  logic [SPC_DATA_W-1:0] nxt_rdata;

  // -----------------------------------------------------------------
  // avalon slave: one wait state on every access
  // -----------------------------------------------------------------
  // the access takes effect in the cycle waitrequest is low
  assign acc_wr = avs_write_i & ~wreq_ff & avs_byteenable_i[0];
  assign acc_rd = avs_read_i & ~wreq_ff;

  // soft reset acts in the accepting cycle and never reads back set
  assign blk_rst = sys_rst_i |
                   (acc_wr & reg_hit(avs_address_i, SPC_OFS_CONTROL) &
                    avs_writedata_i[SPC_SOFT_RST_BIT]);

  // read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_hit(avs_address_i, SPC_OFS_ENABLE)) begin
      nxt_rdata[SPC_EN_BIT] = enable_ff;
    end else if (reg_hit(avs_address_i, SPC_OFS_CONTROL)) begin
      nxt_rdata[6:0] = ctrl_ff;
    end else if (reg_hit(avs_address_i, SPC_OFS_STATUS)) begin
      nxt_rdata[SPC_STS_TXE_BIT] = tx_empty_ff;
      nxt_rdata[SPC_STS_RXF_BIT] = rx_full_ff;
      nxt_rdata[SPC_STS_ACT_BIT] = (state_ff == SPC_SH_RUN);
    end else if (reg_hit(avs_address_i, SPC_OFS_TXDATA)) begin
      nxt_rdata[7:0] = tx_hold_ff;
    end else if (reg_hit(avs_address_i, SPC_OFS_RXDATA)) begin
      nxt_rdata[7:0] = rx_data_ff;
    end
  end

  // handshake: data captured one edge ahead of the accepting edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wreq_ff  <= 1'b1;
      rdata_ff <= '0;
    end else if ((avs_read_i | avs_write_i) & wreq_ff) begin
      wreq_ff  <= 1'b0;
      rdata_ff <= nxt_rdata;
    end else begin
      wreq_ff  <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------
  // block enable
  always_ff @(posedge clock_i) begin
    if (blk_rst) begin
      enable_ff <= 1'b0;
    end else if (acc_wr & reg_hit(avs_address_i, SPC_OFS_ENABLE)) begin
      enable_ff <= avs_writedata_i[SPC_EN_BIT];
    end
  end

  // control; the soft reset field is never stored
  always_ff @(posedge clock_i) begin
    if (blk_rst) begin
      ctrl_ff <= SPC_CTRL_RESET;
    end else if (acc_wr & reg_hit(avs_address_i, SPC_OFS_CONTROL)) begin
      ctrl_ff          <= avs_writedata_i[6:0];
      ctrl_ff.soft_rst <= 1'b0;
    end
  end

  // transmit holding byte and its empty flag
  // a load in the same cycle as a clear wins, so no edge is lost
  always_ff @(posedge clock_i) begin
    if (blk_rst) begin
      tx_hold_ff  <= SPC_BYTE_RESET;
      pending_ff  <= 1'b0;
      tx_empty_ff <= 1'b1;
    end else begin
      if (acc_wr & reg_hit(avs_address_i, SPC_OFS_TXDATA)) begin
        tx_hold_ff <= avs_writedata_i[7:0];
        pending_ff <= 1'b1;
      end else if (load) begin
        pending_ff <= 1'b0;
      end
      if (load) begin
        tx_empty_ff <= 1'b1;
      end else if (acc_wr & reg_hit(avs_address_i, SPC_OFS_TXDATA)) begin
        tx_empty_ff <= 1'b0;
      end else if (acc_rd & ctrl_ff.auto_read &
                   reg_hit(avs_address_i, SPC_OFS_RXDATA)) begin
        tx_empty_ff <= 1'b0;
      end
    end
  end

  // receive byte and its full flag; set beats a clearing read
  always_ff @(posedge clock_i) begin
    if (blk_rst) begin
      rx_data_ff <= SPC_BYTE_RESET;
      rx_full_ff <= 1'b0;
    end else if (byte_done) begin
      rx_data_ff <= rx_sh_ff;
      rx_full_ff <= 1'b1;
    end else if (acc_rd & reg_hit(avs_address_i, SPC_OFS_RXDATA)) begin
      rx_full_ff <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  // pins are asynchronous to clock_i; two stages before any use
  always_ff @(posedge clock_i) begin
    if (blk_rst) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end else begin
      sync1_ff <= {serial_in_second_i, serial_in_first_i};
      sync2_ff <= sync1_ff;
    end
  end

  assign in_bit = pick_bit(sel_ff, dir_ff, bit_cnt_ff[0],
                           sync2_ff);

  // -----------------------------------------------------------------
  // shifter
  // -----------------------------------------------------------------
  // a new byte starts only from idle, so the previous one is whole
  assign load      = (state_ff == SPC_SH_IDLE) & pending_ff &
                     enable_ff;
  assign half_tick = (half_cnt_ff == HCW'(SCLK_HALF - 1));
  assign byte_done = (state_ff == SPC_SH_RUN) & enable_ff & half_tick &
                     sclk_ff & (bit_cnt_ff == BCW'(SPC_BYTE_BITS));

  // state, counters, serial clock and data-out
  // mode 0: data changes on the falling edge, sampled on the rising
  always_ff @(posedge clock_i) begin
    if (blk_rst) begin
      state_ff    <= SPC_SH_IDLE;
      half_cnt_ff <= '0;
      bit_cnt_ff  <= '0;
      tx_sh_ff    <= SPC_BYTE_RESET;
      rx_sh_ff    <= SPC_BYTE_RESET;
      order_ff    <= 1'b0;
      sclk_ff     <= 1'b0;
      sdout_ff    <= 1'b0;
    end else if (!enable_ff) begin
      // disabled: a byte in flight is dropped, outputs go quiet
      state_ff    <= SPC_SH_IDLE;
      half_cnt_ff <= '0;
      sclk_ff     <= 1'b0;
      sdout_ff    <= 1'b0;
    end else begin
      case (state_ff)
        SPC_SH_IDLE: begin
          if (load) begin
            state_ff    <= SPC_SH_RUN;
            tx_sh_ff    <= tx_hold_ff;
            order_ff    <= ctrl_ff.low_bit_first;
            sdout_ff    <= ctrl_ff.low_bit_first ? tx_hold_ff[0] :
                                                   tx_hold_ff[7];
            half_cnt_ff <= '0;
            bit_cnt_ff  <= '0;
            sclk_ff     <= 1'b0;
          end
        end
        SPC_SH_RUN: begin
          if (!half_tick) begin
            half_cnt_ff <= half_cnt_ff + HCW'(1);
          end else begin
            half_cnt_ff <= '0;
            if (!sclk_ff) begin
              // rising edge: sample the selected input
              sclk_ff    <= 1'b1;
              bit_cnt_ff <= bit_cnt_ff + BCW'(1);
              rx_sh_ff   <= order_ff ? {in_bit, rx_sh_ff[7:1]} :
                                       {rx_sh_ff[6:0], in_bit};
            end else begin
              sclk_ff <= 1'b0;
              if (bit_cnt_ff == BCW'(SPC_BYTE_BITS)) begin
                state_ff <= SPC_SH_IDLE;
              end else begin
                // falling edge: present the next bit
                tx_sh_ff <= order_ff ? {1'b0, tx_sh_ff[7:1]} :
                                       {tx_sh_ff[6:0], 1'b0};
                sdout_ff <= order_ff ? tx_sh_ff[1] : tx_sh_ff[6];
              end
            end
          end
        end
        default: begin
          state_ff <= SPC_SH_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // data-out direction
  // -----------------------------------------------------------------
  // only tracked while idle so a byte never sees the buffer turn
  // full duplex keeps the pin an output whatever the control bit says
  always_ff @(posedge clock_i) begin
    if (blk_rst) begin
      dir_ff <= 1'b1;
      sel_ff <= SPC_SEL_FULL;
    end else if (state_ff == SPC_SH_IDLE) begin
      sel_ff <= ctrl_ff.input_pin_choice;
      dir_ff <= (ctrl_ff.input_pin_choice == SPC_SEL_FULL) |
                ctrl_ff.out_pin_drive_dir;
    end
  end

  // chip select follows control bit 6 one cycle later
  always_ff @(posedge clock_i) begin
    if (blk_rst) begin
      cs_n_ff <= 1'b1;
    end else begin
      cs_n_ff <= ~ctrl_ff.cs_on;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all straight from flops
  // -----------------------------------------------------------------
  assign avs_readdata_o             = rdata_ff;
  assign avs_waitrequest_o          = wreq_ff;
  assign link_o.sclk                = sclk_ff;
  assign link_o.cs_n                = cs_n_ff;
  assign link_o.serial_out_pin      = sdout_ff;
  assign link_o.out_pin_dir_signal  = dir_ff;
  assign rx_irq_o                   = rx_full_ff;
  assign tx_irq_o                   = tx_empty_ff;

endmodule

// [spc_serial_ctrl_asserts.sv]
// checker for the serial port control block, bound to its top ports
// assumes a single clock domain and the synchronous high reset
`timescale 1ns/10ps
module spc_serial_ctrl_chk
  import spc_pkg::*;
#(
  parameter int unsigned SCLK_HALF = SPC_SCLK_HALF_CYC
) (
  input wire logic                      clock_i,
  input wire logic                      sys_rst_i,
  input wire logic [SPC_ADDR_W-1:0]     avs_address_i,
  input wire logic                      avs_read_i,
  input wire logic                      avs_write_i,
  input wire logic [SPC_DATA_W-1:0]     avs_writedata_i,
  input wire logic [3:0]                avs_byteenable_i,
  input wire logic [SPC_DATA_W-1:0]     avs_readdata_o,
  input wire logic                      avs_waitrequest_o,
  input wire logic                      serial_in_first_i,
  input wire logic                      serial_in_second_i,
  input wire spc_pkg::spc_link_s        link_o,
  input wire logic                      rx_irq_o,
  input wire logic                      tx_irq_o
);
  logic       acc_w;
  logic       acc_r;
  logic       en_q;
  logic [3:0] rise_cnt;
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // accepted bus transfers
  assign acc_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign acc_r = avs_read_i && !avs_waitrequest_o;
  // mirror of the enable bit; soft reset clears it too
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || (acc_w && avs_address_i == SPC_OFS_CONTROL &&
        avs_writedata_i[4]))
      en_q <= 1'b0;
    else if (acc_w && avs_address_i == SPC_OFS_ENABLE)
      en_q <= avs_writedata_i[0];
  end
  // serial clock pulses per byte; restarts on reconfiguration
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || (acc_w && (avs_address_i == SPC_OFS_ENABLE ||
        avs_writedata_i[4] && avs_address_i == SPC_OFS_CONTROL)))
      rise_cnt <= 4'h0;
    else if ($rose(link_o.sclk))
      rise_cnt <= (rise_cnt == 4'h8) ? 4'h1 : rise_cnt + 4'h1;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest not low for exactly one cycle");
  a_select_drive: assert property (
    acc_w && avs_address_i == SPC_OFS_CONTROL && !avs_writedata_i[4]
    |=> ##1 link_o.cs_n == !$past(avs_writedata_i[6], 2))
    else $error("select output does not follow control bit 6");
  a_tx_write_clear: assert property (
    acc_w && avs_address_i == SPC_OFS_TXDATA |=> ##[0:1] !tx_irq_o)
    else $error("tx write did not clear tx empty");
  a_rx_read_clear: assert property (
    acc_r && avs_address_i == SPC_OFS_RXDATA |=> ##[0:1] !rx_irq_o)
    else $error("rx read did not clear rx full");
  a_eight_pulses: assert property (
    $rose(rx_irq_o) |-> rise_cnt == 4'h8)
    else $error("rx full set without eight clock pulses");
  a_idle_outputs: assert property (
    !en_q && !$past(en_q) && !$past(en_q, 2)
    |-> !link_o.sclk && !link_o.serial_out_pin)
    else $error("link outputs active while disabled");
  a_dir_hold: assert property (
    link_o.sclk |-> $stable(link_o.out_pin_dir_signal))
    else $error("direction changed in mid byte");
  a_reset_values: assert property (disable iff (1'b0)
    sys_rst_i |=> link_o.out_pin_dir_signal && link_o.cs_n &&
    tx_irq_o && !rx_irq_o)
    else $error("wrong output values after reset");
  a_status_zero: assert property (
    acc_r && avs_address_i == SPC_OFS_STATUS
    |-> avs_readdata_o[31:3] == 29'h0)
    else $error("reserved status bits not zero");
  a_ctrl_read: assert property (
    acc_r && avs_address_i == SPC_OFS_CONTROL
    |-> avs_readdata_o[31:7] == 25'h0 && !avs_readdata_o[4])
    else $error("control reserved or soft reset bit reads one");
endmodule

bind spc_serial_ctrl spc_serial_ctrl_chk #(.SCLK_HALF(SCLK_HALF)) u_chk (
  .clock_i            (clock_i),
  .sys_rst_i          (sys_rst_i),
  .avs_address_i      (avs_address_i),
  .avs_read_i         (avs_read_i),
  .avs_write_i        (avs_write_i),
  .avs_writedata_i    (avs_writedata_i),
  .avs_byteenable_i   (avs_byteenable_i),
  .avs_readdata_o     (avs_readdata_o),
  .avs_waitrequest_o  (avs_waitrequest_o),
  .serial_in_first_i  (serial_in_first_i),
  .serial_in_second_i (serial_in_second_i),
  .link_o             (link_o),
  .rx_irq_o           (rx_irq_o),
  .tx_irq_o           (tx_irq_o)
);

// [spc_slave_model.sv]
// serial slave stand-in: answers with a reply byte, records what it got
// assumes mode 0 framing and an active-low select
`timescale 1ns/10ps
module spc_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] reply_i,
  output logic            miso1_o,
  output logic            miso2_o,
  output logic [7:0]      got_o
);
  logic [2:0] idx = 3'h7;
  // ----------------------------------------------------------------
  // shifters
  // ----------------------------------------------------------------
  // next bit on each falling edge; wraps after eight, so bytes chain
  // deselect, or a select not yet known at start-up, rewinds to the msb
  always @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i !== 1'b0)
      idx <= 3'h7;
    else
      idx <= idx - 3'h1;
  end
  // capture msb first on the rising edge
  always @(posedge sclk_i) got_o <= {got_o[6:0], mosi_i};
  // second line carries the inverse so the chosen input is visible;
  // deselected lines flip so a stale bit never looks valid
  assign miso1_o = reply_i[idx] ^ cs_n_i;
  assign miso2_o = ~reply_i[idx] ^ cs_n_i;
endmodule

// [testbench.sv]
// self-checking bench for the serial port control block
// assumes the partner slave model and the bound checker
`timescale 1ns/10ps
module testbench;
  import spc_pkg::*;
  logic                  clock_i = 1'b0;
  logic                  sys_rst_i = 1'b1;
  logic [SPC_ADDR_W-1:0] avs_address_i = 5'h00;
  logic                  avs_read_i = 1'b0;
  logic                  avs_write_i = 1'b0;
  logic [SPC_DATA_W-1:0] avs_writedata_i = 32'h0;
  logic [SPC_DATA_W-1:0] avs_readdata_o;
  logic                  avs_waitrequest_o;
  logic                  serial_in_first_i;
  logic                  serial_in_second_i;
  spc_link_s             link_o;
  logic                  rx_irq_o;
  logic                  tx_irq_o;
  logic [7:0]            reply = 8'h00;
  logic [7:0]            got;
  int                    error_cnt = 0;
  int                    cmp_count = 0;
  // ----------------------------------------------------------------
  // clock, design and partner
  // ----------------------------------------------------------------
  always #25 clock_i = ~clock_i;
  spc_serial_ctrl #(.SCLK_HALF(4)) dut (
    .clock_i            (clock_i),
    .sys_rst_i          (sys_rst_i),
    .avs_address_i      (avs_address_i),
    .avs_read_i         (avs_read_i),
    .avs_write_i        (avs_write_i),
    .avs_writedata_i    (avs_writedata_i),
    .avs_byteenable_i   (4'hF),
    .avs_readdata_o     (avs_readdata_o),
    .avs_waitrequest_o  (avs_waitrequest_o),
    .serial_in_first_i  (serial_in_first_i),
    .serial_in_second_i (serial_in_second_i),
    .link_o             (link_o),
    .rx_irq_o           (rx_irq_o),
    .tx_irq_o           (tx_irq_o)
  );
  spc_slave_model u_slave (
    .sclk_i  (link_o.sclk),
    .cs_n_i  (link_o.cs_n),
    .mosi_i  (link_o.serial_out_pin),
    .reply_i (reply),
    .miso1_o (serial_in_first_i),
    .miso2_o (serial_in_second_i),
    .got_o   (got)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // request held until the edge that sees waitrequest low
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    chk(avs_readdata_o, e);
    avs_read_i <= 1'b0;
  endtask
  // one byte: send t, slave answers r, expect rx er and slave got eg
  task automatic xfer(input logic [7:0] t, input logic [7:0] r,
                      input logic [7:0] er, input logic [7:0] eg);
    reply <= r;
    wr(SPC_OFS_TXDATA, {24'h0, t});
    while (rx_irq_o !== 1'b1) @(posedge clock_i);
    chk({24'h0, got}, {24'h0, eg});
    rdc(SPC_OFS_RXDATA, {24'h0, er});
    repeat (2) @(posedge clock_i);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs well under 4000 cycles
  // ----------------------------------------------------------------
  initial begin
    #200000;
    error_cnt++;
    give_verdict;
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rdc(SPC_OFS_CONTROL, 32'h2);
    rdc(SPC_OFS_STATUS, 32'h1);
    rdc(5'h14, 32'h0);
    wr(SPC_OFS_STATUS, 32'h6);
    rdc(SPC_OFS_STATUS, 32'h1);
    chk(32'({rx_irq_o, tx_irq_o}), 32'h1);
    wr(SPC_OFS_ENABLE, 32'h1);
    wr(SPC_OFS_CONTROL, 32'h40);
    rdc(SPC_OFS_ENABLE, 32'h1);
    chk(32'(link_o.cs_n), 32'h0);
    xfer(8'hA5, 8'h3C, 8'h3C, 8'hA5);
    chk(32'({rx_irq_o, tx_irq_o}), 32'h1);
    wr(SPC_OFS_CONTROL, 32'h41);
    xfer(8'h01, 8'h1D, 8'hB8, 8'h80);
    // half duplex, pin out; second byte queued behind the first
    wr(SPC_OFS_CONTROL, 32'h46);
    reply <= 8'h6A;
    wr(SPC_OFS_TXDATA, 32'hC3);
    repeat (3) @(posedge clock_i);
    while (tx_irq_o !== 1'b1) @(posedge clock_i);
    rdc(SPC_OFS_STATUS, 32'h5);
    wr(SPC_OFS_TXDATA, 32'h7E);
    rdc(SPC_OFS_STATUS, 32'h4);
    wr(SPC_OFS_CONTROL, 32'h44);
    // direction would have turned by now if it were not held
    repeat (2) @(posedge clock_i);
    chk(32'(link_o.out_pin_dir_signal), 32'h1);
    while (rx_irq_o !== 1'b1) @(posedge clock_i);
    chk({24'h0, got}, 32'hC3);
    rdc(SPC_OFS_RXDATA, 32'h6A);
    chk(32'(link_o.out_pin_dir_signal), 32'h0);
    // let the clearing read land before waiting for the next byte
    @(posedge clock_i);
    while (rx_irq_o !== 1'b1) @(posedge clock_i);
    rdc(SPC_OFS_RXDATA, 32'h95);
    wr(SPC_OFS_CONTROL, 32'h4A);
    repeat (2) @(posedge clock_i);
    chk(32'(link_o.out_pin_dir_signal), 32'h1);
    wr(SPC_OFS_CONTROL, 32'h48);
    repeat (2) @(posedge clock_i);
    chk(32'(link_o.out_pin_dir_signal), 32'h0);
    // dual: even bits from the first input, odd from the inverted second
    xfer(8'h00, 8'h96, 8'hC3, 8'h00);
    wr(SPC_OFS_CONTROL, 32'h60);
    xfer(8'h5A, 8'h96, 8'h96, 8'h5A);
    chk(32'({rx_irq_o, tx_irq_o}), 32'h0);
    wr(SPC_OFS_CONTROL, 32'h52);
    rdc(SPC_OFS_CONTROL, 32'h2);
    rdc(SPC_OFS_ENABLE, 32'h0);
    rdc(SPC_OFS_STATUS, 32'h1);
    chk(32'(link_o.cs_n), 32'h1);
    // abort a byte by disabling, then watch the pins stay quiet
    wr(SPC_OFS_ENABLE, 32'h1);
    wr(SPC_OFS_TXDATA, 32'hFF);
    repeat (10) @(posedge clock_i);
    wr(SPC_OFS_ENABLE, 32'h0);
    repeat (3) @(posedge clock_i);
    repeat (16) begin
      @(posedge clock_i);
      chk(32'({link_o.sclk, link_o.serial_out_pin}), 32'h0);
    end
    give_verdict;
  end
endmodule
